// file: gwe_regs.svh
// Offsets, field positions, reset values and timing figures of the wake event block.
// Included by bare name; holds definitions only.
`ifndef GWE_REGS_SVH
`define GWE_REGS_SVH

// Register offsets
`define GWE_OFF_AGG_STATUS 8'h00
`define GWE_OFF_GLOBAL_EN 8'h01
`define GWE_OFF_STS_FIRST 8'h02
`define GWE_OFF_STS_LOW 8'h03
`define GWE_OFF_STS_HIGH 8'h04
`define GWE_OFF_EN_FIRST 8'h05
`define GWE_OFF_EN_LOW 8'h06
`define GWE_OFF_EN_HIGH 8'h07
`define GWE_OFF_MISC_STS 8'h08
`define GWE_OFF_SCAN_CODE 8'h11
`define GWE_OFF_WAKE_OUT_CTRL 8'h16
`define GWE_OFF_DATA_LOW 8'h20
`define GWE_OFF_DATA_HIGH 8'h21
`define GWE_OFF_PIN_CFG_BASE 8'h30
`define GWE_OFF_SNOOP_CLK 8'hf0

// Pin configuration fields
`define GWE_CFG_DIR 0
`define GWE_CFG_POL 1
`define GWE_CFG_BOTH_EDGE 2
`define GWE_CFG_OD 7

// Wake output control, snoop clock control and global enable fields
`define GWE_WOC_POL 1
`define GWE_WOC_OD 7
`define GWE_SNOOP_OFF 1
`define GWE_GLOBAL_EN_BIT 0

// First status/enable register bits
`define GWE_FIRST_RING1 0
`define GWE_FIRST_RING2 1
`define GWE_FIRST_KBD 2
`define GWE_FIRST_MOUSE 3
`define GWE_FIRST_FAN 4
`define GWE_FIRST_SCAN 5

// Both-edge pin positions within the twelve wake pins
`define GWE_DUAL_A 9
`define GWE_DUAL_B 10

// Reset values
`define GWE_RST_PIN_CFG 8'h01
`define GWE_RST_WOC 8'h80
`define GWE_RST_SNOOP 8'h00
`define GWE_RST_SCAN 8'h00

// Timing
`define GWE_MCLK_PERIOD_PS 5000
`define GWE_KBD_IDLE_MIN_NS 115000

`endif

// file: gwe_pkg.sv
// Types and small shared decoders of the wake event block.
// Assumes nothing beyond the register header.
package gwe_pkg;

  typedef enum logic [2:0] {
    GWE_SNOOP_WAIT_IDLE = 3'b001,
    GWE_SNOOP_ARMED = 3'b010,
    GWE_SNOOP_RECV = 3'b100
  } gwe_snoop_state_t;

  // Edge that counts for a pin, chosen by its polarity bit
  function automatic logic gwe_active_edge(input logic inv, input logic rise, input logic fall);
    return inv ? fall : rise;
  endfunction : gwe_active_edge

endpackage : gwe_pkg

// file: gwe_key_snoop.sv
// Keyboard scan-code snooper: watches the keyboard clock and data for one code.
// Assumes keyboard clock and data already synchronised to mclk.
`timescale 1ns/1ps
`include "gwe_regs.svh"
module gwe_key_snoop
  import gwe_pkg::*;
#(
  parameter int IDLE_CYC = 23000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic snoop_on,
  input wire logic [7:0] scan_code,
  // Keyboard lines, synchronised
  input wire logic kbd_clk_s,
  input wire logic kbd_data_s,
  // Result
  output logic match_pulse
);

  localparam int CW = $clog2(IDLE_CYC + 1);

  gwe_snoop_state_t state_q, state_d;
  logic [CW-1:0] high_cnt_q, high_cnt_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic par_ok_q, par_ok_d;
  logic clk_prev_q, clk_prev_d;
  logic match_q, match_d;
  logic fall;
  logic long_high;

  assign fall = clk_prev_q & ~kbd_clk_s;
  assign long_high = (high_cnt_q == CW'(IDLE_CYC));
  assign match_pulse = match_q;

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    par_ok_d = par_ok_q;
    match_d = 1'b0;
    clk_prev_d = kbd_clk_s;
    if (!kbd_clk_s) begin
      high_cnt_d = '0;
    end else if (long_high) begin
      high_cnt_d = high_cnt_q;
    end else begin
      high_cnt_d = high_cnt_q + 1'b1;
    end
    unique case (state_q)
      GWE_SNOOP_WAIT_IDLE: begin
        bit_cnt_d = 4'h0;
        if (long_high) begin
          state_d = GWE_SNOOP_ARMED;
        end
      end
      GWE_SNOOP_ARMED: begin
        if (fall) begin
          // First falling edge after a long high is the start bit
          if (!kbd_data_s) begin
            state_d = GWE_SNOOP_RECV;
            bit_cnt_d = 4'h1;
          end else begin
            state_d = GWE_SNOOP_WAIT_IDLE;
          end
        end
      end
      GWE_SNOOP_RECV: begin
        if (long_high) begin
          // Stalled clock mid-frame would otherwise give a false match
          state_d = GWE_SNOOP_WAIT_IDLE;
        end else if (fall) begin
          bit_cnt_d = bit_cnt_q + 4'h1;
          if (bit_cnt_q <= 4'h8) begin
            shift_d = {kbd_data_s, shift_q[7:1]};
          end else if (bit_cnt_q == 4'h9) begin
            par_ok_d = ^{shift_q, kbd_data_s};
          end else begin
            match_d = kbd_data_s & par_ok_q & (shift_q == scan_code);
            state_d = GWE_SNOOP_WAIT_IDLE;
          end
        end
      end
    endcase
    // Off means held in reset, same as a stopped 32 kHz clock
    if (!snoop_on) begin
      state_d = GWE_SNOOP_WAIT_IDLE;
      high_cnt_d = '0;
      bit_cnt_d = 4'h0;
      match_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= GWE_SNOOP_WAIT_IDLE;
      high_cnt_q <= '0;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      par_ok_q <= 1'b0;
      clk_prev_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      state_q <= state_d;
      high_cnt_q <= high_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      par_ok_q <= par_ok_d;
      clk_prev_q <= clk_prev_d;
      match_q <= match_d;
    end
  end

endmodule : gwe_key_snoop

// file: gwe_wake_logic.sv
// Wake event logic: wake pins, wake sources, status/enable registers, wake request.
// Assumes a simple host register port with one-cycle read and write strobes.
`timescale 1ns/1ps
`include "gwe_regs.svh"
module gwe_wake_logic
  import gwe_pkg::*;
#(
  parameter int KBD_IDLE_CYC =
    (`GWE_KBD_IDLE_MIN_NS * 1000 + `GWE_MCLK_PERIOD_PS - 1) / `GWE_MCLK_PERIOD_PS
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic standby_por,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Wake pins
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe_n,
  // Other wake sources
  input wire logic ring_indicator_one_n,
  input wire logic ring_indicator_two_n,
  input wire logic kbd_clk,
  input wire logic kbd_data,
  input wire logic mouse_data,
  input wire logic fan_tach_event,
  // Wake request to chipset
  output logic wake_request_out,
  output logic wake_request_out_oe_n
);

  localparam int NUM_PINS = 12;
  localparam int NSRC = NUM_PINS + 6;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // Synchroniser and edge state
  logic [NSRC-1:0] raw_in;
  logic [NSRC-1:0] sync1_q, sync1_d;
  logic [NSRC-1:0] sync2_q, sync2_d;
  logic [NSRC-1:0] prev_q, prev_d;
  logic [NSRC-1:0] rise;
  logic [NSRC-1:0] fall;

  assign raw_in = {fan_tach_event, mouse_data, kbd_data, kbd_clk,
                   ring_indicator_two_n, ring_indicator_one_n, pin_in};

  always_comb begin
    sync1_d = raw_in;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  // No reset: the chain fills while reset is held, so a pin already high gives no false edge
  always_ff @(posedge mclk) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    prev_q <= prev_d;
  end

  // Edges taken from the second stage only, so one transition gives one pulse
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // Register state
  logic [7:0] cfg_q [NUM_PINS];
  logic [7:0] cfg_d [NUM_PINS];
  logic [NUM_PINS-1:0] data_q, data_d;
  logic [NUM_PINS-1:0] sts_pin_q, sts_pin_d;
  logic [NUM_PINS-1:0] en_pin_q, en_pin_d;
  logic [5:0] sts_first_q, sts_first_d;
  logic [5:0] en_first_q, en_first_d;
  logic [1:0] misc_q, misc_d;
  logic global_en_q, global_en_d;
  logic [7:0] woc_q, woc_d;
  logic [7:0] snoop_ctl_q, snoop_ctl_d;
  logic [7:0] scan_q, scan_d;
  logic [7:0] rdata_q, rdata_d;
  logic wake_lvl_q, wake_lvl_d;
  logic wake_oe_n_q, wake_oe_n_d;
  logic [NUM_PINS-1:0] pin_out_q, pin_out_d;
  logic [NUM_PINS-1:0] pin_oe_n_q, pin_oe_n_d;

  // Per-pin decode
  logic [NUM_PINS-1:0] dir_in;
  logic [NUM_PINS-1:0] pol;
  logic [NUM_PINS-1:0] both_sel;
  logic [NUM_PINS-1:0] drives;
  logic [NUM_PINS-1:0] pin_set;
  logic [NUM_PINS-1:0] rd_bits;
  logic [NUM_PINS-1:0] drv_val;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    localparam bit DUAL = (g == `GWE_DUAL_A) || (g == `GWE_DUAL_B);
    assign dir_in[g] = cfg_q[g][`GWE_CFG_DIR];
    assign pol[g] = cfg_q[g][`GWE_CFG_POL];
    assign both_sel[g] = DUAL ? cfg_q[g][`GWE_CFG_BOTH_EDGE] : 1'b0;
    // Both-edge mode behaves as an input whatever the direction bit says
    assign drives[g] = ~dir_in[g] & ~both_sel[g];
    assign pin_set[g] = both_sel[g] ? (rise[g] | fall[g]) :
                        (dir_in[g] & gwe_active_edge(pol[g], rise[g], fall[g]));
    assign rd_bits[g] = drives[g] ? data_q[g] : (sync2_q[g] ^ pol[g]);
    assign drv_val[g] = data_q[g] ^ pol[g];
  end

  // First register sources: ring lines active low, data lines on falling edges
  logic [5:0] first_set;
  logic scan_match;
  logic agg_status;
  logic wake_assert;

  assign first_set[`GWE_FIRST_RING1] = fall[NUM_PINS];
  assign first_set[`GWE_FIRST_RING2] = fall[NUM_PINS+1];
  assign first_set[`GWE_FIRST_KBD] = fall[NUM_PINS+3];
  assign first_set[`GWE_FIRST_MOUSE] = fall[NUM_PINS+4];
  assign first_set[`GWE_FIRST_FAN] = rise[NUM_PINS+5];
  assign first_set[`GWE_FIRST_SCAN] = scan_match;

  assign agg_status = |(sts_pin_q & en_pin_q) | |(sts_first_q & en_first_q);
  assign wake_assert = agg_status & global_en_q;

  // Register write, status set and read mux
  always_comb begin
    logic [NUM_PINS-1:0] wmask;
    logic [NUM_PINS-1:0] wval;
    logic [NUM_PINS-1:0] clr_pin;
    logic [5:0] clr_first;
    logic [1:0] clr_misc;
    logic [7:0] rd_val;
    wmask = {(reg_wr && hit(reg_addr, `GWE_OFF_DATA_HIGH)) ? 4'hf : 4'h0,
             (reg_wr && hit(reg_addr, `GWE_OFF_DATA_LOW)) ? 8'hff : 8'h00};
    wval = {reg_wdata[3:0], reg_wdata};
    clr_pin = {(reg_wr && hit(reg_addr, `GWE_OFF_STS_HIGH)) ? reg_wdata[3:0] : 4'h0,
               (reg_wr && hit(reg_addr, `GWE_OFF_STS_LOW)) ? reg_wdata : 8'h00};
    clr_first = (reg_wr && hit(reg_addr, `GWE_OFF_STS_FIRST)) ? reg_wdata[5:0] : 6'h00;
    clr_misc = (reg_wr && hit(reg_addr, `GWE_OFF_MISC_STS)) ? reg_wdata[1:0] : 2'h0;
    rd_val = 8'h00;

    // Writes to input pins do not reach the data flops
    data_d = (data_q & ~(wmask & drives)) | (wval & wmask & drives);
    // Set beats a clear in the same cycle; global enable plays no part
    sts_pin_d = (sts_pin_q & ~clr_pin) | pin_set;
    sts_first_d = (sts_first_q & ~clr_first) | first_set;
    misc_d = (misc_q & ~clr_misc) |
             {rise[`GWE_DUAL_B] | fall[`GWE_DUAL_B], rise[`GWE_DUAL_A] | fall[`GWE_DUAL_A]};

    en_pin_d = en_pin_q;
    en_first_d = en_first_q;
    global_en_d = global_en_q;
    woc_d = woc_q;
    snoop_ctl_d = snoop_ctl_q;
    scan_d = scan_q;
    if (reg_wr) begin
      if (hit(reg_addr, `GWE_OFF_EN_LOW)) begin
        en_pin_d[7:0] = reg_wdata;
      end
      if (hit(reg_addr, `GWE_OFF_EN_HIGH)) begin
        en_pin_d[11:8] = reg_wdata[3:0];
      end
      if (hit(reg_addr, `GWE_OFF_EN_FIRST)) begin
        en_first_d = reg_wdata[5:0];
      end
      if (hit(reg_addr, `GWE_OFF_GLOBAL_EN)) begin
        global_en_d = reg_wdata[`GWE_GLOBAL_EN_BIT];
      end
      if (hit(reg_addr, `GWE_OFF_WAKE_OUT_CTRL)) begin
        woc_d = reg_wdata;
      end
      if (hit(reg_addr, `GWE_OFF_SNOOP_CLK)) begin
        snoop_ctl_d = reg_wdata;
      end
      if (hit(reg_addr, `GWE_OFF_SCAN_CODE)) begin
        scan_d = reg_wdata;
      end
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      cfg_d[i] = cfg_q[i];
      if (reg_wr && hit(reg_addr, 8'(`GWE_OFF_PIN_CFG_BASE + i))) begin
        cfg_d[i] = reg_wdata;
      end
    end

    case (reg_addr)
      `GWE_OFF_AGG_STATUS: rd_val = {7'h00, agg_status};
      `GWE_OFF_GLOBAL_EN: rd_val = {7'h00, global_en_q};
      `GWE_OFF_STS_FIRST: rd_val = {2'h0, sts_first_q};
      `GWE_OFF_STS_LOW: rd_val = sts_pin_q[7:0];
      `GWE_OFF_STS_HIGH: rd_val = {4'h0, sts_pin_q[11:8]};
      `GWE_OFF_EN_FIRST: rd_val = {2'h0, en_first_q};
      `GWE_OFF_EN_LOW: rd_val = en_pin_q[7:0];
      `GWE_OFF_EN_HIGH: rd_val = {4'h0, en_pin_q[11:8]};
      `GWE_OFF_MISC_STS: rd_val = {6'h00, misc_q};
      `GWE_OFF_SCAN_CODE: rd_val = scan_q;
      `GWE_OFF_WAKE_OUT_CTRL: rd_val = woc_q;
      `GWE_OFF_SNOOP_CLK: rd_val = snoop_ctl_q;
      `GWE_OFF_DATA_LOW: rd_val = rd_bits[7:0];
      `GWE_OFF_DATA_HIGH: rd_val = {4'h0, rd_bits[11:8]};
      default: rd_val = 8'h00;
    endcase
    for (int i = 0; i < NUM_PINS; i++) begin
      if (hit(reg_addr, 8'(`GWE_OFF_PIN_CFG_BASE + i))) begin
        rd_val = cfg_q[i];
      end
    end
    // Read data held until the next read strobe latches a new value
    rdata_d = reg_rd ? rd_val : rdata_q;
  end

  // Pin and request drivers; open drain only ever pulls low
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (cfg_q[i][`GWE_CFG_OD]) begin
        pin_out_d[i] = 1'b0;
        pin_oe_n_d[i] = ~(drives[i] & ~drv_val[i]);
      end else begin
        pin_out_d[i] = drv_val[i];
        pin_oe_n_d[i] = ~drives[i];
      end
    end
    wake_lvl_d = woc_q[`GWE_WOC_POL] ? wake_assert : ~wake_assert;
    if (woc_q[`GWE_WOC_OD]) begin
      wake_oe_n_d = wake_lvl_d;
    end else begin
      wake_oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_q[i] <= `GWE_RST_PIN_CFG;
      end
      data_q <= '0;
      sts_pin_q <= '0;
      en_pin_q <= '0;
      sts_first_q <= 6'h00;
      en_first_q <= 6'h00;
      misc_q <= 2'h0;
      global_en_q <= 1'b0;
      woc_q <= `GWE_RST_WOC;
      snoop_ctl_q <= `GWE_RST_SNOOP;
      rdata_q <= 8'h00;
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
      wake_lvl_q <= 1'b1;
      wake_oe_n_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      data_q <= data_d;
      sts_pin_q <= sts_pin_d;
      en_pin_q <= en_pin_d;
      sts_first_q <= sts_first_d;
      en_first_q <= en_first_d;
      misc_q <= misc_d;
      global_en_q <= global_en_d;
      woc_q <= woc_d;
      snoop_ctl_q <= snoop_ctl_d;
      rdata_q <= rdata_d;
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      wake_lvl_q <= wake_lvl_d;
      wake_oe_n_q <= wake_oe_n_d;
    end
  end

  // Scan code lives on standby power; system reset leaves it alone
  always_ff @(posedge mclk) begin
    if (standby_por) begin
      scan_q <= `GWE_RST_SCAN;
    end else begin
      scan_q <= scan_d;
    end
  end

  gwe_key_snoop #(
    .IDLE_CYC(KBD_IDLE_CYC)
  ) u_snoop (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .snoop_on(~snoop_ctl_q[`GWE_SNOOP_OFF]),
    .scan_code(scan_q),
    .kbd_clk_s(sync2_q[NUM_PINS+2]),
    .kbd_data_s(sync2_q[NUM_PINS+3]),
    .match_pulse(scan_match)
  );

  assign reg_rdata = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign wake_request_out = wake_lvl_q;
  assign wake_request_out_oe_n = wake_oe_n_q;

endmodule : gwe_wake_logic

// file: gwe_wake_logic_asserts.sv
// Port-level checker of the wake event block.
// Assumes binding to gwe_wake_logic; shadows a few registers from host writes.
`timescale 1ns/1ps
module gwe_wake_logic_asserts #(
  parameter int KBD_IDLE_CYC = 23000
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic standby_por,
  // Host port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins and sources
  input wire logic [11:0] pin_in,
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe_n,
  input wire logic ring_indicator_one_n,
  input wire logic ring_indicator_two_n,
  input wire logic kbd_clk,
  input wire logic kbd_data,
  input wire logic mouse_data,
  input wire logic fan_tach_event,
  // Wake request
  input wire logic wake_request_out,
  input wire logic wake_request_out_oe_n
);
  logic glob_q;
  logic snoop_q;
  logic [7:0] woc_q;
  logic [7:0] scan_q;
  logic [7:0] en_q;
  logic [7:0] cfg_q;

  function automatic logic hit(input logic [7:0] a);
    return reg_wr && reg_addr == a;
  endfunction : hit

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      glob_q <= 1'b0;
      snoop_q <= 1'b0;
      woc_q <= 8'h80;
      en_q <= 8'h00;
      cfg_q <= 8'h01;
    end else begin
      if (hit(8'h01)) glob_q <= reg_wdata[0];
      if (hit(8'hf0)) snoop_q <= reg_wdata[1];
      if (hit(8'h16)) woc_q <= reg_wdata;
      if (hit(8'h06)) en_q <= reg_wdata;
      if (hit(8'h30)) cfg_q <= reg_wdata;
    end
  end

  // Scan code survives system reset
  always_ff @(posedge mclk) begin
    if (standby_por) scan_q <= 8'h00;
    else if (hit(8'h11)) scan_q <= reg_wdata;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_pin0_rise;
    $rose(pin_in[0]) && cfg_q == 8'h01 && glob_q && en_q[0];
  endsequence
  sequence s_req_on;
    wake_request_out == woc_q[1];
  endsequence

  property p_rd_hold;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");

  property p_glob_off;
    !glob_q && !$past(glob_q) && $stable(woc_q) && $past(woc_q, 2) == woc_q
      |-> wake_request_out == !woc_q[1];
  endproperty
  a_glob_off: assert property (p_glob_off)
    else $error("wake request active with global enable clear");

  property p_pin_wake;
    s_pin0_rise |-> ##[3:6] s_req_on;
  endproperty
  a_pin_wake: assert property (p_pin_wake)
    else $error("enabled pin edge gave no wake request");

  property p_od;
    $past(woc_q[7]) && wake_request_out |-> wake_request_out_oe_n;
  endproperty
  a_od: assert property (p_od)
    else $error("open drain output driving high");

  property p_pp;
    !$past(woc_q[7]) |-> !wake_request_out_oe_n;
  endproperty
  a_pp: assert property (p_pp)
    else $error("push pull output not driving");

  property p_woc_rd;
    reg_rd && reg_addr == 8'h16 && !reg_wr |=> reg_rdata == woc_q;
  endproperty
  a_woc_rd: assert property (p_woc_rd)
    else $error("wake output control readback wrong");

  property p_scan_rd;
    reg_rd && reg_addr == 8'h11 && !reg_wr && !standby_por |=> reg_rdata == scan_q;
  endproperty
  a_scan_rd: assert property (p_scan_rd)
    else $error("scan code readback wrong");

  property p_snoop_rd;
    reg_rd && reg_addr == 8'hf0 && !reg_wr |=> reg_rdata[1] == snoop_q;
  endproperty
  a_snoop_rd: assert property (p_snoop_rd)
    else $error("snoop off bit readback wrong");
endmodule : gwe_wake_logic_asserts

bind gwe_wake_logic gwe_wake_logic_asserts #(.KBD_IDLE_CYC(KBD_IDLE_CYC)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .standby_por(standby_por), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .ring_indicator_one_n(ring_indicator_one_n), .ring_indicator_two_n(ring_indicator_two_n),
  .kbd_clk(kbd_clk), .kbd_data(kbd_data), .mouse_data(mouse_data),
  .fan_tach_event(fan_tach_event), .wake_request_out(wake_request_out),
  .wake_request_out_oe_n(wake_request_out_oe_n));

// file: gwe_chipset_model.sv
// Chipset-side receiver of the wake request.
// Assumes a pull-up on the wire and an active level given by the bench.
`timescale 1ns/1ps
module gwe_chipset_model (
  // Clock
  input wire logic mclk,
  // Active level of the wire
  input wire logic act_high,
  // Request pins of the block
  input wire logic wake_request_out,
  input wire logic wake_request_out_oe_n,
  // Result
  output logic wake_seen
);
  logic line;
  // Released wire rises to the pull-up
  assign line = wake_request_out_oe_n ? 1'b1 : wake_request_out;
  always_ff @(posedge mclk) begin
    wake_seen <= (line == act_high);
  end
endmodule : gwe_chipset_model

// file: gwe_wake_logic_tb_top.sv
// Testbench of the wake event block: registers, pins, sources, snooper.
// Assumes the bound checker and the chipset model beside the block.
`timescale 1ns/1ps
module gwe_wake_logic_tb_top;
  localparam int IDLE = 40;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic standby_por = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [11:0] pin_ext = 12'h000;
  logic [11:0] pin_out;
  logic [11:0] pin_oe_n;
  logic [11:0] pin_w;
  logic [4:0] src = 5'b01111;
  logic kclk = 1'b1;
  logic req;
  logic req_oe_n;
  logic act_hi = 1'b0;
  logic wake_seen;
  logic [7:0] rv;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  // Released pins show the board level; driven pins, open-drain ones pulling low included, show pin_out
  assign pin_w = (pin_oe_n & pin_ext) | (~pin_oe_n & pin_out);

  gwe_wake_logic #(.KBD_IDLE_CYC(IDLE)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .standby_por(standby_por), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_in(pin_w), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ring_indicator_one_n(src[0]), .ring_indicator_two_n(src[1]), .kbd_clk(kclk),
    .kbd_data(src[2]), .mouse_data(src[3]), .fan_tach_event(src[4]),
    .wake_request_out(req), .wake_request_out_oe_n(req_oe_n));
  gwe_chipset_model u_cs (.mclk(mclk), .act_high(act_hi), .wake_request_out(req),
    .wake_request_out_oe_n(req_oe_n), .wake_seen(wake_seen));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cy(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cy

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cy(1);
    reg_wr = 1'b0;
    cy(1);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    cy(1);
    reg_rd = 1'b0;
    rv = reg_rdata;
    chk(rv & m, e);
    cy(1);
  endtask : rdc

  task automatic t_reset;
    rdc(8'h30, 8'hff, 8'h01);
    rdc(8'h16, 8'hff, 8'h80);
    rdc(8'hf0, 8'hff, 8'h00);
    rdc(8'h0f, 8'hff, 8'h00);
  endtask : t_reset

  task automatic t_in_pin;
    pin_ext[0] = 1'b1;
    cy(4);
    rdc(8'h20, 8'h01, 8'h01);
    wr(8'h20, 8'h00);
    rdc(8'h20, 8'h01, 8'h01);
    rdc(8'h03, 8'hff, 8'h01);
    wr(8'h03, 8'h00);
    rdc(8'h03, 8'hff, 8'h01);
    wr(8'h03, 8'h01);
    rdc(8'h03, 8'hff, 8'h00);
    pin_ext[11] = 1'b1;
    cy(4);
    rdc(8'h04, 8'hff, 8'h08);
    wr(8'h30, 8'h03);
    wr(8'h03, 8'h01);
    rdc(8'h20, 8'h01, 8'h00);
    pin_ext[0] = 1'b0;
    cy(4);
    rdc(8'h03, 8'hff, 8'h01);
    wr(8'h30, 8'h01);
    wr(8'h03, 8'hff);
  endtask : t_in_pin

  task automatic t_out_pin;
    wr(8'h31, 8'h00);
    wr(8'h20, 8'h02);
    cy(2);
    chk({pin_oe_n[1], pin_out[1]}, 8'h01);
    rdc(8'h20, 8'h02, 8'h02);
    wr(8'h31, 8'h82);
    cy(2);
    chk({pin_oe_n[1], pin_out[1]}, 8'h00);
    wr(8'h20, 8'h00);
    cy(2);
    chk({pin_oe_n[1], pin_out[1]}, 8'h02);
    rdc(8'h03, 8'hff, 8'h00);
  endtask : t_out_pin

  task automatic t_wake;
    wr(8'h05, 8'h1f);
    for (int s = 0; s < 5; s++) begin
      src[s] = ~src[s];
      cy(6);
      chk(wake_seen, 8'h00);
      rdc(8'h02, 8'h1f, 8'h01 << s);
      src[s] = ~src[s];
      wr(8'h01, 8'h01);
      cy(3);
      chk(wake_seen, 8'h01);
      rdc(8'h00, 8'h01, 8'h01);
      wr(8'h02, 8'h01 << s);
      cy(3);
      chk(wake_seen, 8'h00);
      wr(8'h01, 8'h00);
    end
    wr(8'h05, 8'h00);
    act_hi = 1'b1;
    wr(8'h16, 8'h02);
    wr(8'h01, 8'h01);
    wr(8'h06, 8'h01);
    pin_ext[0] = 1'b1;
    cy(6);
    chk({req_oe_n, req}, 8'h01);
    chk(wake_seen, 8'h01);
    wr(8'h06, 8'h00);
    cy(3);
    chk(wake_seen, 8'h00);
    wr(8'h03, 8'hff);
    wr(8'h01, 8'h00);
    wr(8'h16, 8'h80);
    act_hi = 1'b0;
  endtask : t_wake

  task automatic t_both;
    wr(8'h39, 8'h06);
    pin_ext[9] = 1'b1;
    cy(4);
    rdc(8'h04, 8'h02, 8'h02);
    rdc(8'h08, 8'h03, 8'h01);
    rdc(8'h21, 8'h02, 8'h00);
    chk(pin_oe_n[9], 8'h01);
    wr(8'h07, 8'h02);
    wr(8'h01, 8'h01);
    cy(3);
    chk(wake_seen, 8'h01);
    wr(8'h01, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h08, 8'h01);
    pin_ext[9] = 1'b0;
    cy(4);
    rdc(8'h04, 8'h02, 8'h02);
    rdc(8'h08, 8'h03, 8'h01);
    pin_ext[10] = 1'b1;
    cy(4);
    rdc(8'h08, 8'h03, 8'h03);
    wr(8'h04, 8'h0f);
    wr(8'h08, 8'h03);
  endtask : t_both

  task automatic frame(input logic [7:0] d, input logic pflip, input int n);
    logic [10:0] f;
    f = {1'b1, ~^d ^ pflip, d, 1'b0};
    for (int i = 0; i < n; i++) begin
      src[2] = f[i];
      cy(10);
      kclk = 1'b0;
      cy(10);
      kclk = 1'b1;
    end
    cy(3 * IDLE);
  endtask : frame

  task automatic t_scan;
    wr(8'h11, 8'ha5);
    wr(8'h05, 8'h20);
    wr(8'h01, 8'h01);
    frame(8'ha5, 1'b0, 4);
    frame(8'ha5, 1'b0, 11);
    rdc(8'h02, 8'h20, 8'h20);
    chk(wake_seen, 8'h01);
    wr(8'h02, 8'h20);
    frame(8'ha5, 1'b1, 11);
    frame(8'h5a, 1'b0, 11);
    rdc(8'h02, 8'h20, 8'h00);
    wr(8'hf0, 8'h02);
    frame(8'ha5, 1'b0, 11);
    rdc(8'h02, 8'h20, 8'h00);
    wr(8'hf0, 8'h00);
    wr(8'h05, 8'h00);
    // Snooper was held off, so it must see a long idle again before a start bit
    cy(2 * IDLE);
    frame(8'ha5, 1'b0, 11);
    rdc(8'h02, 8'h20, 8'h20);
    chk(wake_seen, 8'h00);
    wr(8'h02, 8'h3f);
    sys_rst = 1'b1;
    cy(2);
    sys_rst = 1'b0;
    cy(1);
    rdc(8'h11, 8'hff, 8'ha5);
    standby_por = 1'b1;
    cy(1);
    standby_por = 1'b0;
    cy(1);
    rdc(8'h11, 8'hff, 8'h00);
  endtask : t_scan

  initial begin
    cy(8);
    sys_rst = 1'b0;
    standby_por = 1'b0;
    cy(1);
    t_reset();
    t_in_pin();
    t_out_pin();
    t_wake();
    t_both();
    t_scan();
    end_sim();
  end
endmodule : gwe_wake_logic_tb_top
